// ===== rtl/mstp_regs.vh
`ifndef MSTP_REGS_VH
`define MSTP_REGS_VH

// Wishbone register offsets (byte addresses)
`define MSTP_OFS_OFF_TIME  8'h00
`define MSTP_OFS_BLANK     8'h04
`define MSTP_OFS_FAST      8'h08
`define MSTP_OFS_STATUS    8'h0C

// Status register field positions
`define MSTP_ST_POS_LSB    0
`define MSTP_ST_HOME       6
`define MSTP_ST_POL1       7
`define MSTP_ST_POL2       8
`define MSTP_ST_DEC1_LSB   9
`define MSTP_ST_DEC2_LSB   11
`define MSTP_ST_DRV_OK     13

// Clock and timing
`define MSTP_CLK_KHZ       20000
`define MSTP_TOFF_NS       38000
`define MSTP_TBLANK_NS     950
`define MSTP_TFAST_NS      9500
`define MSTP_TOFF_CYC      ((`MSTP_TOFF_NS * `MSTP_CLK_KHZ) / 1000000)
`define MSTP_TBLANK_CYC    ((`MSTP_TBLANK_NS * `MSTP_CLK_KHZ) / 1000000)
`define MSTP_TFAST_CYC     ((`MSTP_TFAST_NS * `MSTP_CLK_KHZ) / 1000000)
`define MSTP_STEP_MIN_NS   1000
`define MSTP_WAKE_NS       1000000

// Translator
`define MSTP_HOME_POS      6'h08
`define MSTP_INC_FULL      6'h10
`define MSTP_INC_HALF      6'h08
`define MSTP_INC_QUARTER   6'h04
`define MSTP_INC_SIXTEENTH 6'h01

// Decay modes
`define MSTP_DEC_SLOW      2'h0
`define MSTP_DEC_FAST      2'h1
`define MSTP_DEC_MIXED     2'h2

// Decay-select level codes
`define MSTP_LVL_FAST      2'h0
`define MSTP_LVL_MIXED     2'h1

`endif

// ===== rtl/mstp_core.v
`timescale 1ns/1ns
`default_nettype none
`include "mstp_regs.vh"

// Function
// - Reset loads home, polarity, mixed decay
// - Step rise advances one resolution increment
// - Select pairs pick full/half/quarter/sixteenth
// - Resolution sampled only at step rise
// - Direction sampled only at step rise
// - Falling level uses select decay, else slow
// - Reset input: home, outputs off, ignore steps
// - Home indicator true at home position, low while reset is held
// - Enable gates outputs; translator still runs
// - Trip turns off source or both sides
// - Fixed off-time then new on-phase
// - Blank comparator after each switching
// - Overtemp or pump undervoltage disables outputs
// - Sink-gate supply fault disables outputs
// - Supply lockout disables drivers, homes translator
// - Sleep disables stages; wake starts at home
// - Select level picks slow, fast, mixed
// - Mixed: fast first, then slow remainder
// - Rectify active; stop at zero current
// - Rectify control high disables rectification
// - Home is 45 degrees, both positive
// - Cosine/sine table, sixteen per quarter
module mstp_core (
  input  wire        clk_i,                  // 20 MHz clock
  input  wire        rst_i,                  // Synchronous reset, active high
  input  wire        cyc_i,                  // Wishbone cycle
  input  wire        stb_i,                  // Wishbone strobe
  input  wire        we_i,                   // Wishbone write enable
  input  wire [7:0]  adr_i,                  // Wishbone byte address
  input  wire [3:0]  sel_i,                  // Wishbone byte selects
  input  wire [31:0] dat_i,                  // Wishbone write data
  output wire [31:0] dat_o,                  // Wishbone read data
  output wire        ack_o,                  // Wishbone acknowledge
  input  wire        step_i,                 // Step input
  input  wire        dir_i,                  // Direction, high = forward
  input  wire        resolution_sel_a_i,     // Resolution select first
  input  wire        resolution_sel_b_i,     // Resolution select second
  input  wire        reset_n_i,              // Translator reset, active low
  input  wire        enable_n_i,             // Output enable, active low
  input  wire        sleep_n_i,              // Sleep, active low
  input  wire [1:0]  decay_select_level_i,   // Decay-select level code
  input  wire        sync_rectify_ctl_i,     // High disables rectification
  input  wire        over_temp_i,            // Overtemperature fault
  input  wire        pump_uv_i,              // Charge pump undervoltage
  input  wire        sink_gate_fault_i,      // Sink-gate supply fault
  input  wire        supply_lockout_i,       // Logic supply undervoltage
  input  wire [1:0]  sense_trip_i,           // Per-bridge current comparator
  input  wire [1:0]  zero_current_i,         // Per-bridge zero current detect
  output wire [1:0]  src_a_o,                // Per-bridge source, side A
  output wire [1:0]  src_b_o,                // Per-bridge source, side B
  output wire [1:0]  snk_a_o,                // Per-bridge sink, side A
  output wire [1:0]  snk_b_o,                // Per-bridge sink, side B
  output wire [7:0]  dac1_o,                 // Phase 1 current magnitude
  output wire [7:0]  dac2_o,                 // Phase 2 current magnitude
  output wire [1:0]  pol_o,                  // Per-phase polarity, 1 = positive
  output wire        home_o                  // Home indicator
);

  localparam ST_ON  = 1'b0;
  localparam ST_OFF = 1'b1;
  // Full-width copies so the 16-bit timing registers take a deliberate slice
  localparam [31:0] TOFF_RST   = `MSTP_TOFF_CYC;
  localparam [31:0] TBLANK_RST = `MSTP_TBLANK_CYC;
  localparam [31:0] TFAST_RST  = `MSTP_TFAST_CYC;

  reg  [15:0] off_time_ff;
  reg  [15:0] blank_ff;
  reg  [15:0] fast_ff;
  reg  [31:0] dat_ff;
  reg         ack_ff;
  reg         step_q_ff;
  reg  [5:0]  pos_ff;
  reg  [7:0]  mag1_ff;
  reg  [7:0]  mag2_ff;
  reg  [1:0]  pol_ff;
  reg  [1:0]  dec1_ff;
  reg  [1:0]  dec2_ff;
  reg         home_ff;
  reg         drv_ok_ff;

  wire        home_force;
  wire        step_rise;
  wire        drv_ok;
  wire        wb_req;
  wire        wb_map;
  reg  [5:0]  inc;
  reg  [5:0]  nxt_pos;
  reg  [1:0]  sel_dec;
  wire [8:0]  ph1;
  wire [8:0]  ph2;
  wire [1:0]  dec_v [0:1];
  wire [7:0]  mag_v [0:1];
  wire [1:0]  pol_v;

  function [7:0] sin_lut;
    input [4:0] k;
    begin
      case (k)
        5'h00: sin_lut = 8'h00;
        5'h01: sin_lut = 8'h19;
        5'h02: sin_lut = 8'h32;
        5'h03: sin_lut = 8'h4A;
        5'h04: sin_lut = 8'h62;
        5'h05: sin_lut = 8'h78;
        5'h06: sin_lut = 8'h8E;
        5'h07: sin_lut = 8'hA2;
        5'h08: sin_lut = 8'hB4;
        5'h09: sin_lut = 8'hC5;
        5'h0A: sin_lut = 8'hD4;
        5'h0B: sin_lut = 8'hE1;
        5'h0C: sin_lut = 8'hEC;
        5'h0D: sin_lut = 8'hF4;
        5'h0E: sin_lut = 8'hFA;
        5'h0F: sin_lut = 8'hFE;
        default: sin_lut = 8'hFF;
      endcase
    end
  endfunction

  // Returns {negative, magnitude}; cosine selects phase 1
  function [8:0] phase_val;
    input [5:0] p;
    input       cosine;
    reg   [4:0] idx;
    reg         neg;
    begin
      idx = (cosine ^ p[4]) ? (5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
      neg = cosine ? (p[5] ^ p[4]) : p[5];
      phase_val = {neg, sin_lut(idx)};
    end
  endfunction

  // Sleep also homes so that wake-up starts from the home position
  assign home_force = rst_i | ~reset_n_i | supply_lockout_i | ~sleep_n_i;
  assign step_rise  = step_i & ~step_q_ff & ~home_force;
  assign drv_ok     = reset_n_i & ~enable_n_i & sleep_n_i & ~over_temp_i & ~pump_uv_i &
                      ~sink_gate_fault_i & ~supply_lockout_i;

  always @* begin
    case ({resolution_sel_b_i, resolution_sel_a_i})
      2'b00:   inc = `MSTP_INC_FULL;
      2'b01:   inc = `MSTP_INC_HALF;
      2'b10:   inc = `MSTP_INC_QUARTER;
      default: inc = `MSTP_INC_SIXTEENTH;
    endcase
    if (dir_i)
      nxt_pos = pos_ff + inc;
    else
      nxt_pos = pos_ff - inc;
    case (decay_select_level_i)
      `MSTP_LVL_FAST:  sel_dec = `MSTP_DEC_FAST;
      `MSTP_LVL_MIXED: sel_dec = `MSTP_DEC_MIXED;
      default:         sel_dec = `MSTP_DEC_SLOW;
    endcase
  end

  assign ph1 = phase_val(nxt_pos, 1'b1);
  assign ph2 = phase_val(nxt_pos, 1'b0);

  always @(posedge clk_i) begin
    step_q_ff <= step_i;
    drv_ok_ff <= drv_ok & ~rst_i;
    if (home_force) begin
      pos_ff  <= `MSTP_HOME_POS;
      mag1_ff <= 8'hB4;
      mag2_ff <= 8'hB4;
      pol_ff  <= 2'b11;
      dec1_ff <= `MSTP_DEC_MIXED;
      dec2_ff <= `MSTP_DEC_MIXED;
    end else if (step_rise) begin
      pos_ff  <= nxt_pos;
      mag1_ff <= ph1[7:0];
      mag2_ff <= ph2[7:0];
      pol_ff  <= {~ph2[8], ~ph1[8]};
      dec1_ff <= (ph1[7:0] < mag1_ff) ? sel_dec : `MSTP_DEC_SLOW;
      dec2_ff <= (ph2[7:0] < mag2_ff) ? sel_dec : `MSTP_DEC_SLOW;
    end
    // Low while reset is held even though the position is home
    home_ff <= ~rst_i & reset_n_i & (home_force | (pos_ff == `MSTP_HOME_POS));
  end

  assign dec_v[0] = dec1_ff;
  assign dec_v[1] = dec2_ff;
  assign mag_v[0] = mag1_ff;
  assign mag_v[1] = mag2_ff;
  assign pol_v    = pol_ff;

  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bridge
      reg        state_ff;
      reg [15:0] blank_cnt_ff;
      reg [15:0] off_cnt_ff;
      reg [15:0] fast_cnt_ff;
      reg        zc_ff;
      reg        src_a_ff;
      reg        src_b_ff;
      reg        snk_a_ff;
      reg        snk_b_ff;
      reg        nxt_src_a;
      reg        nxt_src_b;
      reg        nxt_snk_a;
      reg        nxt_snk_b;
      reg        fast_now;
      wire       trip;

      // Comparator ignored while blanking runs
      assign trip = sense_trip_i[b] & (blank_cnt_ff == 16'h0000);

      always @(posedge clk_i) begin
        if (rst_i || !drv_ok) begin
          state_ff     <= ST_ON;
          blank_cnt_ff <= blank_ff;
          off_cnt_ff   <= 16'h0000;
          fast_cnt_ff  <= 16'h0000;
          zc_ff        <= 1'b0;
        end else if (state_ff == ST_ON) begin
          if (blank_cnt_ff != 16'h0000)
            blank_cnt_ff <= blank_cnt_ff - 16'h0001;
          if (trip) begin
            state_ff     <= ST_OFF;
            off_cnt_ff   <= off_time_ff;
            fast_cnt_ff  <= (dec_v[b] == `MSTP_DEC_MIXED) ? fast_ff : 16'h0000;
            blank_cnt_ff <= blank_ff;
            zc_ff        <= 1'b0;
          end
        end else begin
          if (blank_cnt_ff != 16'h0000)
            blank_cnt_ff <= blank_cnt_ff - 16'h0001;
          if (fast_cnt_ff != 16'h0000)
            fast_cnt_ff <= fast_cnt_ff - 16'h0001;
          if (zero_current_i[b])
            zc_ff <= 1'b1;
          if (off_cnt_ff <= 16'h0001) begin
            state_ff     <= ST_ON;
            blank_cnt_ff <= blank_ff;
          end else begin
            off_cnt_ff <= off_cnt_ff - 16'h0001;
          end
        end
      end

      always @* begin
        nxt_src_a = 1'b0;
        nxt_src_b = 1'b0;
        nxt_snk_a = 1'b0;
        nxt_snk_b = 1'b0;
        fast_now  = (dec_v[b] == `MSTP_DEC_FAST) ||
                    ((dec_v[b] == `MSTP_DEC_MIXED) && (fast_cnt_ff != 16'h0000));
        if (!drv_ok || rst_i) begin
          nxt_src_a = 1'b0;
        end else if (state_ff == ST_ON) begin
          nxt_src_a = pol_v[b];
          nxt_snk_b = pol_v[b];
          nxt_src_b = ~pol_v[b];
          nxt_snk_a = ~pol_v[b];
        end else if (!fast_now) begin
          // Slow decay: source off, diagonal sink stays on
          nxt_snk_b = pol_v[b];
          nxt_snk_a = ~pol_v[b];
          if (!sync_rectify_ctl_i && !zc_ff) begin
            nxt_snk_a = 1'b1;
            nxt_snk_b = 1'b1;
          end
        end else if (!sync_rectify_ctl_i && !zc_ff) begin
          // Fast decay with rectification: opposite diagonal on
          nxt_src_b = pol_v[b];
          nxt_snk_a = pol_v[b];
          nxt_src_a = ~pol_v[b];
          nxt_snk_b = ~pol_v[b];
        end
      end

      // Gate drives registered so they leave the block glitch-free
      always @(posedge clk_i) begin
        src_a_ff <= nxt_src_a;
        src_b_ff <= nxt_src_b;
        snk_a_ff <= nxt_snk_a;
        snk_b_ff <= nxt_snk_b;
      end

      assign src_a_o[b] = src_a_ff;
      assign src_b_o[b] = src_b_ff;
      assign snk_a_o[b] = snk_a_ff;
      assign snk_b_o[b] = snk_b_ff;
    end
  endgenerate

  assign wb_req = cyc_i & stb_i & ~ack_ff;
  assign wb_map = (adr_i[7:4] == 4'h0);

  always @(posedge clk_i) begin
    if (rst_i) begin
      off_time_ff <= TOFF_RST[15:0];
      blank_ff    <= TBLANK_RST[15:0];
      fast_ff     <= TFAST_RST[15:0];
      ack_ff      <= 1'b0;
      dat_ff      <= 32'h00000000;
    end else begin
      ack_ff <= wb_req;
      if (wb_req && we_i && wb_map) begin
        case ({4'h0, adr_i[3:2], 2'b00})
          `MSTP_OFS_OFF_TIME: begin
            if (sel_i[0]) off_time_ff[7:0]  <= dat_i[7:0];
            if (sel_i[1]) off_time_ff[15:8] <= dat_i[15:8];
          end
          `MSTP_OFS_BLANK: begin
            if (sel_i[0]) blank_ff[7:0]  <= dat_i[7:0];
            if (sel_i[1]) blank_ff[15:8] <= dat_i[15:8];
          end
          `MSTP_OFS_FAST: begin
            if (sel_i[0]) fast_ff[7:0]  <= dat_i[7:0];
            if (sel_i[1]) fast_ff[15:8] <= dat_i[15:8];
          end
          default: begin
          end
        endcase
      end
      dat_ff <= 32'h00000000;
      if (wb_req && !we_i && wb_map) begin
        case ({4'h0, adr_i[3:2], 2'b00})
          `MSTP_OFS_OFF_TIME: dat_ff <= {16'h0000, off_time_ff};
          `MSTP_OFS_BLANK:    dat_ff <= {16'h0000, blank_ff};
          `MSTP_OFS_FAST:     dat_ff <= {16'h0000, fast_ff};
          default: begin
            dat_ff[`MSTP_ST_POS_LSB+5:`MSTP_ST_POS_LSB]   <= pos_ff;
            dat_ff[`MSTP_ST_HOME]                         <= home_ff;
            dat_ff[`MSTP_ST_POL1]                         <= pol_ff[0];
            dat_ff[`MSTP_ST_POL2]                         <= pol_ff[1];
            dat_ff[`MSTP_ST_DEC1_LSB+1:`MSTP_ST_DEC1_LSB] <= dec1_ff;
            dat_ff[`MSTP_ST_DEC2_LSB+1:`MSTP_ST_DEC2_LSB] <= dec2_ff;
            dat_ff[`MSTP_ST_DRV_OK]                       <= drv_ok_ff;
          end
        endcase
      end
    end
  end

  assign dat_o  = dat_ff;
  assign ack_o  = ack_ff;
  assign dac1_o = mag1_ff;
  assign dac2_o = mag2_ff;
  assign pol_o  = pol_ff;
  assign home_o = home_ff;

endmodule

`default_nettype wire

// ===== rtl/mstp_dummy_none.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== tb/mstp_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module mstp_core_assertions (
  input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o, step_i, // Bus and step
  input wire logic        reset_n_i, enable_n_i, sleep_n_i, over_temp_i, // Controls
  input wire logic        pump_uv_i, sink_gate_fault_i, supply_lockout_i, // Faults
  input wire logic        sync_rectify_ctl_i, home_o, // Rectify control, home flag
  input wire logic [31:0] dat_o, // Read data
  input wire logic [1:0]  src_a_o, src_b_o, snk_a_o, snk_b_o, pol_o, // Gates, polarity
  input wire logic [7:0]  dac1_o, dac2_o // Magnitudes
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic run, off, at_home;
  assign run = reset_n_i && sleep_n_i && !supply_lockout_i;
  assign off = !run || enable_n_i || over_temp_i || pump_uv_i || sink_gate_fault_i;
  assign at_home = dac1_o == 8'hB4 && dac2_o == 8'hB4 && pol_o == 2'h3;
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  rd_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not idle");
  gates_off_a: assert property (off |=> (src_a_o | src_b_o | snk_a_o | snk_b_o) == 2'h0)
    else $error("gates on while disabled");
  home_low_a: assert property (!reset_n_i |=> !home_o) else $error("home high in reset");
  home_pos_a: assert property (!run |=> at_home) else $error("not held at home");
  step_only_a: assert property (run && !$rose(step_i) |=>
    $stable(dac1_o) && $stable(dac2_o) && $stable(pol_o)) else $error("moved without step");
  home_flag_a: assert property (run && !$past(rst_i) && $past(reset_n_i) && at_home
    |=> home_o) else $error("home flag missing");
  no_shoot_a: assert property ((src_a_o & snk_a_o) == 2'h0 && (src_b_o & snk_b_o) == 2'h0)
    else $error("same side both on");
  diag_pair_a: assert property ((src_a_o & ~snk_b_o) == 2'h0 && (src_b_o & ~snk_a_o) == 2'h0)
    else $error("source without diagonal sink");
  no_rectify_a: assert property (sync_rectify_ctl_i && $past(sync_rectify_ctl_i)
    |-> (snk_a_o & snk_b_o) == 2'h0) else $error("rectification while disabled");
  cover property (ack_o);
  cover property (run && $rose(step_i));
  cover property ($fell(home_o));
  cover property (src_a_o[0] && snk_b_o[0]);
endmodule
`default_nettype wire

// ===== tb/mstp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module mstp_ctrl_model (
  input  wire logic       clk_i,   // Bench clock
  input  wire logic       rst_i,   // Sync reset
  input  wire logic       go_i,    // Start request
  input  wire logic [3:0] cmd_i,   // {pulse, dir, res a, res b}
  output logic            step_o,  // Step line
  output logic            dir_o,   // Direction line
  output logic            res_a_o, // Resolution select first
  output logic            res_b_o, // Resolution select second
  output logic            busy_o   // Pulse in progress
);
  logic [5:0] cnt_ff;
  assign busy_o = cnt_ff != 6'h00;
  // Lines settle 4 cycles before the rise, then 20 high and 20 low
  assign step_o = cnt_ff > 6'h04 && cnt_ff < 6'h19;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 6'h00;
      {dir_o, res_a_o, res_b_o} <= 3'h4;
    end else if (cnt_ff == 6'h00) begin
      if (go_i) begin
        {dir_o, res_a_o, res_b_o} <= cmd_i[2:0];
        cnt_ff <= {5'h00, cmd_i[3]};
      end
    end else begin
      cnt_ff <= (cnt_ff == 6'h2C) ? 6'h00 : cnt_ff + 6'h01;
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_mstp_core.sv
`timescale 1ns/1ns
`default_nettype none
module test_mstp_core;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, reset_n_i = 1, go = 0;
  logic sync_rectify_ctl_i = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, cmd = 4'h0;
  logic [31:0] dat_i = 32'h0, e, m;
  logic [5:0] flt = 6'h00;
  logic [1:0] decay_select_level_i = 2'h0, sense_trip_i = 2'h0, zero_current_i = 2'h0;
  logic [1:0] dtab [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  int inc [4] = '{16, 4, 8, 1};
  wire step_i, dir_i, resolution_sel_a_i, resolution_sel_b_i, busy, ack_o, home_o;
  wire enable_n_i, over_temp_i, pump_uv_i, sink_gate_fault_i, supply_lockout_i, sleep_n_i;
  wire [31:0] dat_o;
  wire [1:0] src_a_o, src_b_o, snk_a_o, snk_b_o, pol_o;
  wire [7:0] dac1_o, dac2_o;
  int n_mismatch = 0, cmp_count = 0;
  logic [31:0] q_exp [$], q_msk [$];
  string q_nm [$], nm;
  assign {sleep_n_i, supply_lockout_i, sink_gate_fault_i, pump_uv_i, over_temp_i, enable_n_i}
    = flt ^ 6'h20;
  mstp_core dut_u (.*);
  mstp_ctrl_model ctl_u (.clk_i, .rst_i, .go_i(go), .cmd_i(cmd), .step_o(step_i),
    .dir_o(dir_i), .res_a_o(resolution_sel_a_i), .res_b_o(resolution_sel_b_i), .busy_o(busy));
  initial forever #25 clk_i = ~clk_i;
  // Comparator and zero-current inputs wander so the regulator keeps switching
  always @(posedge clk_i) {sense_trip_i, zero_current_i, sync_rectify_ctl_i} <= 5'($urandom);
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo(input string w);
    n_mismatch++;
    $display("[FAIL] %s expected done seen timeout", w);
    test_done();
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1) tmo("ack");
    {cyc_i, stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k,
      input string s);
    q_exp.push_back(x);
    q_msk.push_back(k);
    q_nm.push_back(s);
    wb(a, 1'b0, 32'h0, 4'hF);
  endtask
  task automatic stp(input logic [3:0] c);
    int n;
    n = 0;
    cmd <= c;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy !== 1'b0 && n < 100);
    if (busy !== 1'b0) tmo("step");
  endtask
  task automatic chk(input string s, input logic [18:0] x, input logic [18:0] v);
    cmp_count++;
    if (v !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, x, v);
    end
  endtask
  // Home the translator; the full step issued meanwhile must be ignored
  task automatic hr;
    reset_n_i <= 1'b0;
    stp(4'hC);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] st(input logic [5:0] p, input logic h,
      input logic [1:0] pl, input logic [1:0] d1, input logic [1:0] d2);
    return {18'h0, 1'b1, d2, d1, pl, h, p};
  endfunction
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      cmp_count++;
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      nm = q_nm.pop_front();
      if ((dat_o & m) !== (e & m)) begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", nm, e & m, dat_o & m);
      end
    end
  end
  initial begin
    logic [5:0] p;
    void'($urandom(32'h03EA));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h2F8, 32'hFFFFFFFF, "off time");
    rd(8'h04, 32'h13, 32'hFFFFFFFF, "blank");
    rd(8'h08, 32'hBE, 32'hFFFFFFFF, "fast");
    rd(8'h0C, st(6'h08, 1'b1, 2'h3, 2'h2, 2'h2), 32'hFFFFFFFF, "status");
    rd(8'h40, 32'h0, 32'hFFFFFFFF, "unmapped");
    wb(8'h0C, 1'b1, 32'h3F, 4'hF);
    rd(8'h0C, st(6'h08, 1'b1, 2'h3, 2'h2, 2'h2), 32'hFFFFFFFF, "status write");
    wb(8'h00, 1'b1, 32'hFFFF1204, 4'h1);
    rd(8'h00, 32'h204, 32'hFFFFFFFF, "byte lane");
    wb(8'h00, 1'b1, 32'h4, 4'h3);
    wb(8'h04, 1'b1, 32'h2, 4'h3);
    wb(8'h08, 1'b1, 32'h2, 4'h3);
    for (int i = 0; i < 4; i++) begin
      hr();
      stp({2'h3, 2'(i)});
      rd(8'h0C, 32'(8 + inc[i]), 32'h3F, "resolution");
    end
    hr();
    stp(4'hC);
    rd(8'h0C, st(6'h18, 1'b0, 2'h2, 2'h0, 2'h0), 32'hFFFFFFFF, "full fwd");
    chk("outputs fwd", {1'b0, 2'h2, 8'hB4, 8'hB4}, {home_o, pol_o, dac1_o, dac2_o});
    stp(4'h8);
    rd(8'h0C, st(6'h08, 1'b1, 2'h3, 2'h0, 2'h0), 32'hFFFFFFFF, "full back");
    stp(4'h8);
    rd(8'h0C, st(6'h38, 1'b0, 2'h1, 2'h0, 2'h0), 32'hFFFFFFFF, "wrap back");
    stp(4'h0);
    rd(8'h0C, 32'h38, 32'h3F, "lines only");
    stp(4'hF);
    rd(8'h0C, 32'h39, 32'h3F, "sixteenth");
    for (int c = 0; c < 4; c++) begin
      hr();
      decay_select_level_i <= 2'(c);
      stp(4'hF);
      rd(8'h0C, st(6'h09, 1'b0, 2'h3, dtab[c], 2'h0), 32'hFFFFFFFF, "decay");
      chk("outputs sixteenth", {1'b0, 2'h3, 8'hA2, 8'hC5}, {home_o, pol_o, dac1_o, dac2_o});
    end
    p = 6'h09;
    for (int f = 0; f < 6; f++) begin
      flt <= 6'h01 << f;
      if (f == 0) stp(4'hF);
      else repeat (3) @(posedge clk_i);
      p = (f == 0) ? 6'h0A : (f > 3) ? 6'h08 : p;
      rd(8'h0C, 32'(p), 32'h203F, "disable");
      flt <= 6'h00;
      repeat ((f == 5) ? 20000 : 3) @(posedge clk_i);
      rd(8'h0C, 32'h2000, 32'h2000, "resume");
    end
    stp(4'hF);
    rd(8'h0C, 32'h09, 32'h3F, "after wake");
    test_done();
  end
endmodule
bind mstp_core mstp_core_assertions chk_u (.*);
`default_nettype wire
